// ===== rtl/smc_regs.vh
// Purpose: Register map, field positions, reset values and timing counts of the serial channel.
// Assumes: 32-bit register bus with byte addresses and one aligned word per register.
// Notes: Included by the channel module only.
`ifndef SMC_REGS_VH
`define SMC_REGS_VH

// Register byte offsets.
`define SMC_OFF_MODE_ONE 12'h000
`define SMC_OFF_MODE_TWO 12'h004
`define SMC_OFF_CONFIG 12'h008
`define SMC_OFF_TX_DATA 12'h00c
`define SMC_OFF_RX_DATA 12'h010

// Fields of mode_control_one.
`define SMC_M1_IDLE_RUN 7
`define SMC_M1_DIR_HI 6
`define SMC_M1_DIR_LO 5
`define SMC_M1_TXE 4
`define SMC_M1_GAP_HI 3
`define SMC_M1_GAP_LO 1

// Fields of mode_control_two.
`define SMC_M2_TBEMP 7
`define SMC_M2_RX_BUFFER_FULL_FLAG 6
`define SMC_M2_TXRUN 5
`define SMC_M2_STOP2 4
`define SMC_M2_MSB_FIRST 3
`define SMC_M2_DOUBLE_BUFFER_ENABLE 2

// Fields of the configuration register.
`define SMC_CF_FIFO_EN 4
`define SMC_CF_FMT_HI 3
`define SMC_CF_FMT_LO 2
`define SMC_CF_RXE 1
`define SMC_CF_CLK_OUT 0

// Reset values.
`define SMC_RST_MODE_ONE 8'h00
`define SMC_RST_MODE_TWO 8'h80
`define SMC_RST_CONFIG 8'h00

// Transfer format codes.
`define SMC_FMT_CLOCKED 2'h0
`define SMC_FMT_UART7 2'h1
`define SMC_FMT_UART8 2'h2

// Timing counts in system clock cycles, and the clocked transfer length in bits.
`define SMC_SCLK_HALF 4
`define SMC_BAUD_DIV 16
`define SMC_CLOCKED_BITS 4'h8

`endif

// ===== rtl/smc_top.v
// Purpose: Mode control, status flags and serial engine of a clocked-serial or UART channel.
// Assumes: CLK_I at 20 MHz; SCLK_I and RXD_I are asynchronous; IDLE_I and CE_I are on CLK_I.
// Notes: Only a single transmit hold buffer exists; no FIFO storage is built here.
// What this block does
// - The idle-run bit lets the channel keep working (1) or freezes it (0) in IDLE.
// - In clocked mode the direction field allows none, receive, transmit or both.
// - With the FIFO on the direction field also shapes it; in UART it limits nothing.
// - The transmit-enable bit gates every transmission in every format.
// - The gap field inserts 0, 1, 2, 4, 8, 16 or 64 serial clocks between transfers.
// - The gap acts only in clocked mode while the device drives the serial clock.
// - The gap acts only on continuous sending with double buffering or FIFO on.
// - The transmit-buffer-empty flag reads 0 when the buffer is full, 1 when empty.
// - Moving buffered data into the shift register sets transmit-buffer-empty.
// - A software write of transmit data clears transmit-buffer-empty.
// - The receive-buffer-full flag reads 0 when empty and 1 when holding data.
// - A finished receive sets receive-buffer-full and a read of the flag clears it.
// - Transmit-active and buffer-empty together show running, done or waiting.
// - The format field picks clocked mode or 7-, 8- or 9-bit UART.
`timescale 1ns/1ps
`default_nettype none
`include "smc_regs.vh"
module smc_top #(
  parameter SCLK_HALF = `SMC_SCLK_HALF,
  parameter BAUD_DIV = `SMC_BAUD_DIV
) (
  input wire CLK_I,
  input wire RSTN_I,
  input wire CE_I,
  input wire IDLE_I,
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [11:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  output reg [31:0] PRDATA_O,
  output wire PREADY_O,
  output wire PSLVERR_O,
  input wire RXD_I,
  output reg TXD_O,
  input wire SCLK_I,
  output reg SCLK_O,
  output wire SCLK_OE_O,
  output wire [1:0] FIFO_CFG_O
);
  // State codes of the transmit engine and of the UART receiver.
  localparam T_IDLE = 2'h0, T_SHIFT = 2'h1, T_GAP = 2'h2;
  localparam R_IDLE = 1'b0, R_RUN = 1'b1;
  // Control and status storage.
  reg [7:0] mode_one, mode_two, config_reg;
  reg [8:0] tx_hold, rx_buf;
  reg hold_full, rx_buffer_full_flag;
  // Engine storage.
  reg [1:0] tx_state;
  reg tx_loaded, r_state;
  reg [11:0] tx_shift;
  reg [3:0] bit_cnt, r_bits;
  reg [15:0] div_cnt, gap_cnt, r_cnt;
  reg [7:0] rx_shift;
  reg [10:0] r_frame;
  // Three-stage synchronisers; stage one is read only by stage two.
  reg [2:0] sclk_sync, rxd_sync;
  // Decoded controls.
  wire [1:0] fmt = config_reg[`SMC_CF_FMT_HI:`SMC_CF_FMT_LO];
  wire clocked = (fmt == `SMC_FMT_CLOCKED);
  wire clk_out = config_reg[`SMC_CF_CLK_OUT];
  wire [1:0] dir = mode_one[`SMC_M1_DIR_HI:`SMC_M1_DIR_LO];
  wire transmit_enable = mode_one[`SMC_M1_TXE];
  wire receive_enable = config_reg[`SMC_CF_RXE];
  wire msb_first = mode_two[`SMC_M2_MSB_FIRST];
  wire double_buffer_enable = mode_two[`SMC_M2_DOUBLE_BUFFER_ENABLE];
  wire active = CE_I & (~IDLE_I | mode_one[`SMC_M1_IDLE_RUN]);
  wire tx_ok = transmit_enable & (~clocked | dir[1]);
  wire rx_ok = receive_enable & (~clocked | dir[0]);
  wire txrun = (tx_state == T_SHIFT) & tx_loaded;
  wire gap_used = clocked & clk_out & (double_buffer_enable | config_reg[`SMC_CF_FIFO_EN]);
  // Edges of the external serial clock, read only from the second and third stages.
  wire ext_rise = sclk_sync[1] & ~sclk_sync[2];
  wire ext_fall = ~sclk_sync[1] & sclk_sync[2];
  wire rxd_s2 = rxd_sync[1];
  wire rxd_s3 = rxd_sync[2];
  wire div_end = (div_cnt == SCLK_HALF - 1);
  wire gen_rise = clk_out & (tx_state == T_SHIFT) & div_end & ~SCLK_O;
  wire gen_fall = clk_out & (tx_state == T_SHIFT) & div_end & SCLK_O;
  wire s_rise = clk_out ? gen_rise : ext_rise;
  wire s_fall = clk_out ? gen_fall : ext_fall;
  wire baud_end = (div_cnt == BAUD_DIV - 1);
  // Bus decode; every access completes in its first access cycle.
  wire acc = PSEL_I & PENABLE_I;
  wire wr = acc & PWRITE_I;
  wire rd = acc & ~PWRITE_I;
  wire hit_m1 = (PADDR_I == `SMC_OFF_MODE_ONE);
  wire hit_m2 = (PADDR_I == `SMC_OFF_MODE_TWO);
  wire hit_cf = (PADDR_I == `SMC_OFF_CONFIG);
  wire hit_tx = (PADDR_I == `SMC_OFF_TX_DATA);
  wire hit_rx = (PADDR_I == `SMC_OFF_RX_DATA);
  wire mapped = hit_m1 | hit_m2 | hit_cf | hit_tx | hit_rx;
  wire [7:0] m2_view = {~hold_full, rx_buffer_full_flag, txrun, mode_two[4:2], 2'h0};
  // Bus answer, pin drive and the FIFO arrangement outputs.
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = acc & ~mapped;
  assign SCLK_OE_O = clocked & clk_out;
  assign FIFO_CFG_O = config_reg[`SMC_CF_FIFO_EN] ? dir : 2'h0;
  // Reverses a byte for most-significant-bit-first clocked transfers.
  function [7:0] flip8;
    input [7:0] d;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1)
        flip8[i] = d[7 - i];
    end
  endfunction
  // Serial clock periods for a gap code: 0, 1, 2, 4, 8, 16 or 64; reserved 110 gives none.
  function [6:0] gap_periods;
    input [2:0] code;
    begin
      gap_periods = (code == 3'h0 || code == 3'h6) ? 7'h00 :
                    (code == 3'h7) ? 7'h40 : 7'h01 << (code - 3'h1);
    end
  endfunction
  // Number of line bits in a transfer: clocked byte, or start, data and stop bits.
  function [3:0] frame_bits;
    input [1:0] f;
    input stop2;
    begin
      frame_bits = (f == 2'h0) ? `SMC_CLOCKED_BITS : 4'h8 + {2'h0, f} + {3'h0, stop2};
    end
  endfunction
  // Synchronisers for the serial clock and receive data pins; both rest high.
  always @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      sclk_sync <= 3'h7;
      rxd_sync <= 3'h7;
    end
    else if (CE_I)
    begin
      sclk_sync <= {sclk_sync[1:0], SCLK_I};
      rxd_sync <= {rxd_sync[1:0], RXD_I};
    end
  end
  // Register writes and the hold buffer flag.
  always @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      mode_one <= `SMC_RST_MODE_ONE;
      mode_two <= `SMC_RST_MODE_TWO;
      config_reg <= `SMC_RST_CONFIG;
      tx_hold <= 9'h000;
      hold_full <= 1'b0;
    end
    else if (CE_I)
    begin
      if (wr && hit_m1)
        mode_one <= {PWDATA_I[7:1], 1'b0};
      if (wr && hit_m2)
        mode_two <= {3'h0, PWDATA_I[4:2], 2'h0};
      if (wr && hit_cf)
        config_reg <= {3'h0, PWDATA_I[4:0]};
      if (wr && hit_tx)
      begin
        tx_hold <= PWDATA_I[8:0];
        hold_full <= 1'b1;
      end
      else if (active && tx_state == T_IDLE && tx_ok && hold_full)
        hold_full <= 1'b0;
    end
  end
  // Read data mux; the upper bits of each word read as zero.
  always @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      PRDATA_O <= 32'h00000000;
    else if (CE_I && PSEL_I && !PENABLE_I && !PWRITE_I)
    begin
      if (hit_m1)
        PRDATA_O <= {24'h000000, mode_one};
      else if (hit_m2)
        PRDATA_O <= {24'h000000, m2_view};
      else if (hit_cf)
        PRDATA_O <= {24'h000000, config_reg};
      else if (hit_rx)
        PRDATA_O <= {23'h000000, rx_buf};
      else
        PRDATA_O <= 32'h00000000;
    end
  end
  // Transmit engine shared by both formats; the clocked receiver rides on its clock.
  always @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      tx_state <= T_IDLE;
      tx_loaded <= 1'b0;
      tx_shift <= 12'hfff;
      bit_cnt <= 4'h0;
      div_cnt <= 16'h0000;
      gap_cnt <= 16'h0000;
      rx_shift <= 8'h00;
      TXD_O <= 1'b1;
      SCLK_O <= 1'b1;
    end
    else if (active)
    begin
      case (tx_state)
        T_IDLE:
        begin
          div_cnt <= 16'h0000;
          SCLK_O <= 1'b1;
          bit_cnt <= frame_bits(fmt, mode_two[`SMC_M2_STOP2]);
          if (tx_ok && hold_full)
          begin
            tx_state <= T_SHIFT;
            tx_loaded <= 1'b1;
            if (clocked)
            begin
              tx_shift <= {4'hf, msb_first ? flip8(tx_hold[7:0]) : tx_hold[7:0]};
              TXD_O <= msb_first ? tx_hold[7] : tx_hold[0];
            end
            else
            begin
              // Bits above the character width are forced high so they act as stop bits.
              tx_shift <= {2'h3, tx_hold | (9'h1ff << (4'h6 + {2'h0, fmt})), 1'b0};
              TXD_O <= 1'b0;
            end
          end
          else if (clocked && rx_ok && !rx_buffer_full_flag)
          begin
            tx_state <= T_SHIFT; // Receive-only transfer, line held high.
            tx_loaded <= 1'b0;
            tx_shift <= 12'hfff;
          end
        end
        T_SHIFT:
        begin
          if (clocked)
          begin
            div_cnt <= div_end ? 16'h0000 : div_cnt + 16'h0001;
            if (gen_rise || gen_fall)
              SCLK_O <= ~SCLK_O;
            if (s_fall && bit_cnt != `SMC_CLOCKED_BITS)
            begin
              tx_shift <= {1'b1, tx_shift[11:1]};
              TXD_O <= tx_shift[1] | ~tx_loaded;
            end
            if (s_rise)
            begin
              rx_shift <= {rxd_s2, rx_shift[7:1]};
              bit_cnt <= bit_cnt - 4'h1;
              if (bit_cnt == 4'h1)
              begin
                tx_loaded <= 1'b0;
                TXD_O <= 1'b1;
                div_cnt <= 16'h0000;
                gap_cnt <= {3'h0, gap_periods(mode_one[`SMC_M1_GAP_HI:`SMC_M1_GAP_LO]), 6'h00};
                if (gap_used && hold_full && tx_ok &&
                    gap_periods(mode_one[`SMC_M1_GAP_HI:`SMC_M1_GAP_LO]) != 7'h00)
                  tx_state <= T_GAP;
                else
                  tx_state <= T_IDLE;
              end
            end
          end
          else
          begin
            div_cnt <= baud_end ? 16'h0000 : div_cnt + 16'h0001;
            if (baud_end)
            begin
              bit_cnt <= bit_cnt - 4'h1;
              tx_shift <= {1'b1, tx_shift[11:1]};
              if (bit_cnt == 4'h1)
              begin
                tx_state <= T_IDLE;
                tx_loaded <= 1'b0;
                TXD_O <= 1'b1;
              end
              else
                TXD_O <= tx_shift[1];
            end
          end
        end
        T_GAP:
        begin
          // Each gap unit counts one serial clock period of two half periods.
          if (div_cnt == 2 * SCLK_HALF - 1)
          begin
            div_cnt <= 16'h0000;
            gap_cnt <= gap_cnt - 16'h0040;
            if (gap_cnt == 16'h0040)
              tx_state <= T_IDLE;
          end
          else
            div_cnt <= div_cnt + 16'h0001;
        end
        default: tx_state <= T_IDLE;
      endcase
    end
  end
  // UART receiver: centre-samples start, data and stop bits.
  always @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      r_state <= R_IDLE;
      r_cnt <= 16'h0000;
      r_bits <= 4'h0;
      r_frame <= 11'h000;
    end
    else if (active)
    begin
      case (r_state)
        R_IDLE:
        begin
          r_cnt <= 16'h0000;
          r_bits <= frame_bits(fmt, 1'b0);
          if (!clocked && rx_ok && !rxd_s2 && rxd_s3)
            r_state <= R_RUN;
        end
        R_RUN:
        begin
          if (r_cnt == ((r_bits == frame_bits(fmt, 1'b0)) ? BAUD_DIV / 2 - 1 : BAUD_DIV - 1))
          begin
            r_cnt <= 16'h0000;
            r_frame <= {rxd_s2, r_frame[10:1]};
            r_bits <= r_bits - 4'h1;
            if (r_bits == frame_bits(fmt, 1'b0) && rxd_s2)
              r_state <= R_IDLE; // False start.
            else if (r_bits == 4'h1)
              r_state <= R_IDLE;
          end
          else
            r_cnt <= r_cnt + 16'h0001;
        end
        default: r_state <= R_IDLE;
      endcase
    end
  end
  // Receive buffer and its full flag; a new character wins over a clearing read.
  wire clk_rx_done = clocked & (tx_state == T_SHIFT) & s_rise & (bit_cnt == 4'h1) & rx_ok;
  wire uart_rx_done = (r_state == R_RUN) & (r_bits == 4'h1) & (r_cnt == BAUD_DIV - 1);
  always @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      rx_buf <= 9'h000;
      rx_buffer_full_flag <= 1'b0;
    end
    else if (CE_I)
    begin
      if (active && clk_rx_done)
      begin
        rx_buf <= {1'b0, msb_first ? flip8({rxd_s2, rx_shift[7:1]}) : {rxd_s2, rx_shift[7:1]}};
        rx_buffer_full_flag <= 1'b1;
      end
      else if (active && uart_rx_done)
      begin
        // The stop bit is not yet shifted in; narrower characters sit higher in the frame.
        rx_buf <= r_frame[10:2] >> (2'h3 - fmt);
        rx_buffer_full_flag <= 1'b1;
      end
      else if (rd && hit_m2)
        rx_buffer_full_flag <= 1'b0;
    end
  end

endmodule // smc_top

`default_nettype wire

// ===== dv/smc_checker.sv
// Purpose: Port assertions for the serial channel.
// Assumes: Bound to smc_top; bus accesses are spaced three edges apart.
// Notes: Shadows the mode fields from bus writes.
`timescale 1ns/1ps
`default_nettype none
module smc_checker (
  input wire CLK_I,
  input wire RSTN_I,
  input wire CE_I,
  input wire IDLE_I,
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [11:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  input wire [31:0] PRDATA_O,
  input wire TXD_O,
  input wire SCLK_O,
  input wire SCLK_OE_O,
  input wire [1:0] FIFO_CFG_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  logic [7:0] m1;
  logic [7:0] cf;
  wire acc = PSEL_I && PENABLE_I && CE_I;
  // Shadow copies of the mode fields, taken at the access edge.
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      m1 <= 8'h00;
      cf <= 8'h00;
    end
    else if (acc && PWRITE_I && PADDR_I == 12'h000)
      m1 <= PWDATA_I[7:0];
    else if (acc && PWRITE_I && PADDR_I == 12'h008)
      cf <= PWDATA_I[7:0];
  end
  sequence rd_two;
    acc && !PWRITE_I && PADDR_I == 12'h004;
  endsequence
  sequence wr_data_held;
    acc && PWRITE_I && PADDR_I == 12'h00c && !m1[4];
  endsequence
  AST_M1_READ:
    assert property (acc && !PWRITE_I && PADDR_I == 12'h000 |-> PRDATA_O == {24'h0, m1[7:1], 1'b0})
    else $error("mode one read differs");
  AST_M2_UPPER:
    assert property (rd_two |-> PRDATA_O[31:8] == 24'h0 && PRDATA_O[1:0] == 2'h0)
    else $error("mode two reserved bits set");
  AST_FIFO_CFG:
    assert property (FIFO_CFG_O == (cf[4] ? m1[6:5] : 2'h0))
    else $error("fifo arrangement wrong");
  AST_CLK_OE:
    assert property (SCLK_OE_O == (cf[3:2] == 2'h0 && cf[0]))
    else $error("clock drive enable wrong");
  AST_TX_GATE:
    assert property ($fell(TXD_O) |-> $past(m1[4]))
    else $error("transmit without enable");
  AST_RX_ONLY:
    assert property ($fell(TXD_O) && cf[3:2] == 2'h0 |-> m1[6])
    else $error("clocked transmit while not allowed");
  AST_IDLE_HOLD:
    assert property (IDLE_I && !m1[7] |=> $stable(TXD_O) && $stable(SCLK_O))
    else $error("engine ran while halted");
  AST_RX_CLEAR:
    assert property (rd_two ##0 PRDATA_O[6] ##3 rd_two |-> !PRDATA_O[6])
    else $error("receive flag not cleared by read");
  AST_TB_CLEAR:
    assert property (wr_data_held ##3 rd_two |-> !PRDATA_O[7])
    else $error("buffer empty after data write");
endmodule // smc_checker
`default_nettype wire

// ===== dv/smc_peer.sv
// Purpose: Far-side serial partner: UART capture and clocked sender.
// Assumes: Bit time of BAUD system cycles; link clock period 400 ns.
// Notes: Lines rest high outside frames, like pulled-up pins.
`timescale 1ns/1ps
`default_nettype none
module smc_peer #(
  parameter int BAUD = 4
) (
  input wire logic clk_i,
  input wire logic txd_i,
  output logic rxd_o,
  output logic sclk_o
);
  // Both lines idle high.
  initial
  begin
    rxd_o = 1'b1;
    sclk_o = 1'b1;
  end
  // Captures n bits after a start bit, sampled mid-bit.
  task automatic get_uart(input int n, output logic [8:0] d);
    d = 9'h0;
    @(negedge txd_i);
    repeat (BAUD / 2) @(posedge clk_i);
    for (int i = 0; i < n; i++)
    begin
      repeat (BAUD) @(posedge clk_i);
      d[i] = txd_i;
    end
  endtask
  // Sends a UART character LSB first with one stop bit, then one idle bit time.
  task automatic send_uart(input int n, input logic [8:0] d);
    @(posedge clk_i);
    rxd_o <= 1'b0;
    repeat (BAUD) @(posedge clk_i);
    for (int i = 0; i < n; i++)
    begin
      rxd_o <= d[i];
      repeat (BAUD) @(posedge clk_i);
    end
    rxd_o <= 1'b1;
    repeat (2 * BAUD) @(posedge clk_i);
  endtask
  // Sends a byte LSB first; data moves on the falling clock edge.
  task automatic send_clk(input logic [7:0] d);
    #13;
    for (int i = 0; i < 8; i++)
    begin
      sclk_o = 1'b0;
      rxd_o = d[i];
      #200;
      sclk_o = 1'b1;
      #200;
    end
    rxd_o = 1'b1;
  endtask
endmodule // smc_peer
`default_nettype wire

// ===== dv/tb_top.sv
// Purpose: Self-checking bench for the serial channel.
// Assumes: Short counts SCLK_HALF 2 and BAUD_DIV 4.
// Notes: Each scenario is one task.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int H = 2;
  localparam int BAUD = 4;
  logic CLK_I = 1'b0;
  logic RSTN_I = 1'b0;
  logic CE_I = 1'b1;
  logic IDLE_I = 1'b0;
  logic PSEL_I = 1'b0;
  logic PENABLE_I = 1'b0;
  logic PWRITE_I = 1'b0;
  logic [11:0] PADDR_I = 12'h000;
  logic [31:0] PWDATA_I = 32'h0;
  wire [31:0] PRDATA_O;
  wire [1:0] FIFO_CFG_O;
  wire PREADY_O, PSLVERR_O, TXD_O, SCLK_O, SCLK_OE_O, RXD_I, SCLK_I;
  logic [31:0] q;
  logic err;
  int fails = 0;
  int cmp_count = 0;
  smc_top #(.SCLK_HALF(H), .BAUD_DIV(BAUD)) dut (.CLK_I(CLK_I), .RSTN_I(RSTN_I),
    .CE_I(CE_I), .IDLE_I(IDLE_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .RXD_I(RXD_I), .TXD_O(TXD_O),
    .SCLK_I(SCLK_I), .SCLK_O(SCLK_O), .SCLK_OE_O(SCLK_OE_O), .FIFO_CFG_O(FIFO_CFG_O));
  smc_peer #(.BAUD(BAUD)) peer (.clk_i(CLK_I), .txd_i(TXD_O), .rxd_o(RXD_I),
    .sclk_o(SCLK_I));
  // 20 MHz system clock.
  initial
  begin
    forever #25 CLK_I = ~CLK_I;
  end
  // One bus transfer; read data and error are taken at the ready edge.
  task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK_I);
    PSEL_I <= 1'b1;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= d;
    @(posedge CLK_I);
    PENABLE_I <= 1'b1;
    do
      @(posedge CLK_I);
    while (PREADY_O !== 1'b1);
    q = PRDATA_O;
    err = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
    #1;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic stop_test;
    $display("fails %0d cmp_count %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic t_regs;
    xf(0, 12'h000, 0);
    chk(q, 32'h0);
    xf(0, 12'h004, 0);
    chk(q, 32'h80);
    xf(1, 12'h000, 32'hffffffef);
    xf(0, 12'h000, 0);
    chk(q, 32'hee);
    xf(1, 12'h000, 0);
    xf(1, 12'h004, 32'hffffffff);
    xf(0, 12'h004, 0);
    chk(q, 32'h9c);
    xf(0, 12'h040, 0);
    chk(q, 32'h0);
    chk(err, 1'b1);
    xf(1, 12'h004, 32'h4);
    CE_I <= 1'b0;
    xf(1, 12'h000, 32'h80);
    CE_I <= 1'b1;
    xf(0, 12'h000, 0);
    chk(q, 32'h0);
  endtask
  task automatic t_cfg;
    for (int i = 0; i < 4; i++)
    begin
      xf(1, 12'h008, 32'h10);
      xf(1, 12'h000, i << 5);
      chk(FIFO_CFG_O, i);
      xf(1, 12'h008, 32'h8);
      chk(FIFO_CFG_O, 0);
    end
    xf(1, 12'h008, 32'h1);
    chk(SCLK_OE_O, 1'b1);
    xf(1, 12'h008, 32'h9);
    chk(SCLK_OE_O, 1'b0);
    xf(1, 12'h000, 0);
  endtask
  task automatic t_uart;
    logic [8:0] d;
    for (int f = 1; f < 4; f++)
    begin
      xf(1, 12'h008, f << 2);
      xf(1, 12'h00c, 32'h1a5);
      xf(0, 12'h004, 0);
      chk(q & 32'ha0, 32'h0);
      fork
        peer.get_uart(f + 6, d);
        begin
          xf(1, 12'h000, 32'h10);
          repeat (3 * BAUD) @(posedge CLK_I);
          xf(0, 12'h004, 0);
          chk(q & 32'ha0, 32'ha0);
        end
      join
      repeat (3 * BAUD) @(posedge CLK_I);
      xf(0, 12'h004, 0);
      chk(q & 32'ha0, 32'h80);
      chk(d, 32'h1a5 & ((32'h1 << (f + 6)) - 1));
      xf(1, 12'h000, 0);
    end
  endtask
  task automatic t_idle;
    logic [8:0] d;
    xf(1, 12'h008, 32'h8);
    xf(1, 12'h00c, 32'h55);
    IDLE_I <= 1'b1;
    xf(1, 12'h000, 32'h10);
    repeat (40) @(posedge CLK_I);
    chk(TXD_O, 1'b1);
    fork
      peer.get_uart(8, d);
      IDLE_I <= 1'b0;
    join
    chk(d, 32'h55);
    repeat (3 * BAUD) @(posedge CLK_I);
    IDLE_I <= 1'b1;
    fork
      peer.get_uart(8, d);
      begin
        xf(1, 12'h000, 32'h90);
        xf(1, 12'h00c, 32'h33);
      end
    join
    chk(d, 32'h33);
    repeat (3 * BAUD) @(posedge CLK_I);
    IDLE_I <= 1'b0;
    xf(1, 12'h000, 0);
  endtask
  // Two back-to-back clocked bytes; n counts cycles up to the 16th clock rise.
  task automatic gap_run(input logic [2:0] c, output int n);
    int k;
    logic p;
    k = 0;
    p = 1'b1;
    n = 0;
    xf(1, 12'h008, 32'h1);
    xf(1, 12'h000, {24'h0, 4'h5, c, 1'b0});
    fork
      begin
        xf(1, 12'h00c, 32'h3c);
        xf(1, 12'h00c, 32'hc3);
      end
      begin
        wait (SCLK_O === 1'b0);
        while (k < 16)
        begin
          @(posedge CLK_I);
          n++;
          if (SCLK_O === 1'b1 && p === 1'b0)
            k++;
          p = SCLK_O;
        end
      end
    join
    repeat (8) @(posedge CLK_I);
    xf(1, 12'h000, 0);
  endtask
  task automatic t_gap;
    int b;
    int n;
    gap_run(3'h0, b);
    gap_run(3'h4, n);
    chk(n - b, 8 * 2 * H);
    gap_run(3'h7, n);
    chk(n - b, 64 * 2 * H);
    gap_run(3'h6, n);
    chk(n - b, 0);
    xf(1, 12'h004, 32'h0);
    gap_run(3'h4, n);
    chk(n - b, 0);
  endtask
  task automatic t_uartrx;
    xf(1, 12'h008, 32'ha);
    peer.send_uart(8, 9'h0c5);
    xf(0, 12'h004, 0);
    chk(q[6], 1'b1);
    xf(0, 12'h010, 0);
    chk(q, 32'hc5);
    xf(1, 12'h008, 32'he);
    peer.send_uart(9, 9'h1c5);
    xf(0, 12'h004, 0);
    chk(q[6], 1'b1);
    xf(0, 12'h010, 0);
    chk(q, 32'h1c5);
  endtask
  task automatic t_clkrx;
    xf(1, 12'h008, 32'h2);
    xf(1, 12'h000, 32'h20);
    peer.send_clk(8'h96);
    repeat (10) @(posedge CLK_I);
    xf(0, 12'h004, 0);
    chk(q[6], 1'b1);
    xf(0, 12'h004, 0);
    chk(q[6], 1'b0);
    xf(0, 12'h010, 0);
    chk(q, 32'h96);
    xf(1, 12'h004, 32'h8);
    peer.send_clk(8'h96);
    repeat (10) @(posedge CLK_I);
    xf(0, 12'h010, 0);
    chk(q, 32'h69);
  endtask
  // Main sequence.
  initial
  begin
    repeat (10) @(posedge CLK_I);
    RSTN_I <= 1'b1;
    t_regs;
    t_cfg;
    t_uart;
    t_idle;
    t_gap;
    t_uartrx;
    t_clkrx;
    stop_test;
  end
  // Watchdog against a hang.
  initial
  begin
    repeat (40000) @(posedge CLK_I);
    fails++;
    stop_test;
  end
endmodule // tb_top
bind smc_top smc_checker u_chk (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .CE_I(CE_I),
  .IDLE_I(IDLE_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
  .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .TXD_O(TXD_O),
  .SCLK_O(SCLK_O), .SCLK_OE_O(SCLK_OE_O), .FIFO_CFG_O(FIFO_CFG_O));
`default_nettype wire
